// file: design/uicr_pkg.sv
// package for the usb interrupt-clear and fifo-clear register bank
// assumes a 32-bit ahb-lite bus with registers one aligned word each
package uicr_pkg;

    // register indices; byte address is four times the index
    localparam logic [29:0] IDX_BULK_OUT_IRQ_CLEAR      = 30'h0000FF4D;
    localparam logic [29:0] IDX_SET_INTERFACE_IRQ_CLEAR = 30'h0000FF4E;
    localparam logic [29:0] IDX_EP0_BULK_IN_FIFO_CLEAR  = 30'h0000FF79;
    localparam logic [29:0] IDX_BULK_OUT_FIFO_CLEAR     = 30'h0000FF7A;

    // read-back values of the write-only registers
    localparam logic [7:0]  IRQ_CLEAR_READ  = 8'hFF;
    localparam logic [7:0]  FIFO_CLEAR_READ = 8'h00;
    localparam logic [31:0] UNMAPPED_READ   = 32'h00000000;

    // bulk-out interrupt clear / status bit positions
    localparam int BO_FULL_BIT = 3;
    localparam int BO_NULL_BIT = 2;
    localparam int BO_NAK_BIT  = 1;
    localparam int BO_DATA_BIT = 0;
    localparam int BO_BITS     = 4;

    // set-interface interrupt clear bit
    localparam int SETIF_BIT = 5;

    // first fifo clear register bits
    localparam int BI_SIE_CLR_BIT = 5;
    localparam int BI_CPU_CLR_BIT = 4;
    localparam int EP0_TX_CLR_BIT = 1;
    localparam int EP0_RX_CLR_BIT = 0;

    // second fifo clear register bits
    localparam int BO_BOTH_CLR_BIT = 1;
    localparam int BO_CPU_CLR_BIT  = 0;

    // latched status after reset
    localparam logic [3:0] BO_STATUS_RESET    = 4'h0;
    localparam logic       SETIF_STATUS_RESET = 1'b0;

    // ahb encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ    = 2'h3;
    localparam logic       HRESP_OKAY    = 1'b0;

endpackage

// file: design/uicr_regs.sv
// ahb-lite register bank clearing usb interrupt latches and fifo counters
// assumes event, flag and enable inputs come from logic on clk
//
// Behaviour
// - interrupt clear registers are write-only bytes and read back as all ones
// - a zero written to a defined clear bit clears its latched source
// - firmware can clear a source before hardware would clear it itself
// - clear bits return to one by themselves; register idles at all ones
// - clear bits do nothing while their endpoint is not enabled
// - bulk-out clear bits 3..0 map to full, null, nak and data sources
// - set-interface clear bit 5 clears its source; other bits do nothing
// - fifo clear registers are write-only bytes and read back as zero
// - a one written to a fifo clear bit resets that fifo counter
// - fifo clear bits return to zero after the clear is done
// - bit 5 empties only the serial-side half of the bulk-in buffer
// - serial-side clear is ignored during an in token with nak flag set
// - serial-side bulk-in clear also clears the bulk-in nak flag
// - bit 4 empties only the cpu-side half of the bulk-in buffer
// - bit 1 empties ep0 transmit buffer and clears its nak flag
// - bit 0 empties the ep0 receive buffer
// - ep0 receive clear drops the rx nak flag only when hardware set it
// - second register bit 1 empties both halves of the bulk-out buffer
// - second register bit 0 empties only the cpu-side bulk-out half
// - bulk-out clears drop the bulk-out nak flag only when hardware set it
//
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module uicr_regs
(
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        ce,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // endpoint enables and interface configuration
    input  wire logic        inEndpointEnable,
    input  wire logic        outEndpointEnable,
    input  wire logic        ifaceBulkInActive,
    input  wire logic        ifaceBulkOutActive,
    // hardware interrupt events, one-cycle pulses
    input  wire logic        bulkOutFullEvent,
    input  wire logic        bulkOutNullEvent,
    input  wire logic        bulkOutNakEvent,
    input  wire logic        bulkOutDataEvent,
    input  wire logic        setInterfaceEvent,
    // state of flags held in the serial engine
    input  wire logic        bulkInTokenBusy,
    input  wire logic        bulkInNakFlag,
    input  wire logic        ep0RxNakSetByHw,
    input  wire logic        bulkOutNakSetByHw,
    // latched interrupt sources
    output logic [3:0]       bulkOutIrqStatus,
    output logic             setInterfaceIrqStatus,
    // fifo counter clears, one-cycle pulses
    output logic             bulkInSerialSideClear,
    output logic             bulkInCpuSideClear,
    output logic             ep0TxBufferClear,
    output logic             ep0RxBufferClear,
    output logic             bulkOutFullClear,
    output logic             bulkOutCpuSideClear,
    // nak flag clears, one-cycle pulses
    output logic             bulkInNakClear,
    output logic             ep0TxNakClear,
    output logic             ep0RxNakClear,
    output logic             bulkOutNakClear
);

    logic        wrPend_q;
    logic [29:0] wrIdx_q;
    logic [31:0] rdata_q;
    logic        bulkInEn;
    logic        bulkOutEn;
    logic        setIfEn;
    logic        wrStrobe;
    logic [7:0]  wrByte;
    logic        wrBoIrq;
    logic        wrSetIf;
    logic        wrFic0;
    logic        wrFic1;
    logic        addrTaken;
    logic [3:0]  boEvents;
    logic [3:0]  boClear;
    logic        setIfClear;
    logic        biSieDo;
    logic        boAnyClr;
    logic [3:0]  bulkOutIrqStatus_q;
    logic        setInterfaceIrqStatus_q;
    logic [9:0]  pulse_q;
    logic [9:0]  pulse_d;

    // zero-wait slave, always okay
    assign hreadyout = 1'b1;
    assign hresp     = uicr_pkg::HRESP_OKAY;
    assign hrdata    = rdata_q;

    // address phase accepted
    assign addrTaken = hsel & hready & ((htrans == uicr_pkg::HTRANS_NONSEQ) | (htrans == uicr_pkg::HTRANS_SEQ));

    // endpoint gating by enable setting and current interface
    assign bulkInEn  = inEndpointEnable & ifaceBulkInActive;
    assign bulkOutEn = outEndpointEnable & ifaceBulkOutActive;
    assign setIfEn   = bulkInEn | bulkOutEn;

    // write data phase decode, low byte carries the register
    assign wrStrobe = ce & wrPend_q;
    assign wrByte   = hwdata[7:0];
    assign wrBoIrq  = wrStrobe & (wrIdx_q == uicr_pkg::IDX_BULK_OUT_IRQ_CLEAR);
    assign wrSetIf  = wrStrobe & (wrIdx_q == uicr_pkg::IDX_SET_INTERFACE_IRQ_CLEAR);
    assign wrFic0   = wrStrobe & (wrIdx_q == uicr_pkg::IDX_EP0_BULK_IN_FIFO_CLEAR);
    assign wrFic1   = wrStrobe & (wrIdx_q == uicr_pkg::IDX_BULK_OUT_FIFO_CLEAR);

    // capture write address phase
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            wrPend_q <= 1'b0;
            wrIdx_q  <= 30'h00000000;
        end
        else if (ce)
        begin
            wrPend_q <= addrTaken & hwrite;
            if (addrTaken)
                wrIdx_q <= haddr[31:2];
        end
    end

    // read data registered in the address phase
    always_ff @(posedge clk)
    begin
        if (srst)
            rdata_q <= uicr_pkg::UNMAPPED_READ;
        else if (ce && addrTaken && !hwrite)
        begin
            case (haddr[31:2])
                uicr_pkg::IDX_BULK_OUT_IRQ_CLEAR,
                uicr_pkg::IDX_SET_INTERFACE_IRQ_CLEAR:
                    rdata_q <= {24'h000000, uicr_pkg::IRQ_CLEAR_READ};
                uicr_pkg::IDX_EP0_BULK_IN_FIFO_CLEAR,
                uicr_pkg::IDX_BULK_OUT_FIFO_CLEAR:
                    rdata_q <= {24'h000000, uicr_pkg::FIFO_CLEAR_READ};
                default:
                    rdata_q <= uicr_pkg::UNMAPPED_READ;
            endcase
        end
    end

    // bulk-out clear bits: write zero clears, one is ignored
    assign boEvents = {bulkOutFullEvent, bulkOutNullEvent, bulkOutNakEvent, bulkOutDataEvent};
    assign boClear  = {uicr_pkg::BO_BITS{wrBoIrq & bulkOutEn}} & ~wrByte[3:0];
    assign setIfClear = wrSetIf & setIfEn & ~wrByte[uicr_pkg::SETIF_BIT];

    // latched bulk-out sources, event wins over clear
    generate
        for (genvar i = 0; i < uicr_pkg::BO_BITS; i++)
        begin : g_bo
            always_ff @(posedge clk)
            begin
                if (srst)
                    bulkOutIrqStatus_q[i] <= uicr_pkg::BO_STATUS_RESET[i];
                else if (ce)
                begin
                    if (boEvents[i])
                        bulkOutIrqStatus_q[i] <= 1'b1;
                    else if (boClear[i])
                        bulkOutIrqStatus_q[i] <= 1'b0;
                end
            end
        end
    endgenerate

    // latched set-interface source
    always_ff @(posedge clk)
    begin
        if (srst)
            setInterfaceIrqStatus_q <= uicr_pkg::SETIF_STATUS_RESET;
        else if (ce)
        begin
            if (setInterfaceEvent)
                setInterfaceIrqStatus_q <= 1'b1;
            else if (setIfClear)
                setInterfaceIrqStatus_q <= 1'b0;
        end
    end

    assign bulkOutIrqStatus      = bulkOutIrqStatus_q;
    assign setInterfaceIrqStatus = setInterfaceIrqStatus_q;

    // fifo clear decode: ones act, zeros ignored
    assign biSieDo  = wrFic0 & bulkInEn & wrByte[uicr_pkg::BI_SIE_CLR_BIT]
                      & ~(bulkInTokenBusy & bulkInNakFlag);
    assign boAnyClr = wrFic1 & bulkOutEn
                      & (wrByte[uicr_pkg::BO_BOTH_CLR_BIT] | wrByte[uicr_pkg::BO_CPU_CLR_BIT]);

    always_comb
    begin
        pulse_d    = 10'h000;
        pulse_d[0] = biSieDo;
        pulse_d[1] = wrFic0 & bulkInEn & wrByte[uicr_pkg::BI_CPU_CLR_BIT];
        pulse_d[2] = wrFic0 & wrByte[uicr_pkg::EP0_TX_CLR_BIT];
        pulse_d[3] = wrFic0 & wrByte[uicr_pkg::EP0_RX_CLR_BIT];
        pulse_d[4] = wrFic1 & bulkOutEn & wrByte[uicr_pkg::BO_BOTH_CLR_BIT];
        pulse_d[5] = wrFic1 & bulkOutEn & wrByte[uicr_pkg::BO_CPU_CLR_BIT];
        pulse_d[6] = biSieDo;
        pulse_d[7] = pulse_d[2];
        pulse_d[8] = pulse_d[3] & ep0RxNakSetByHw;
        pulse_d[9] = boAnyClr & bulkOutNakSetByHw;
    end

    // clear pulses last one enabled cycle, then drop back to zero
    always_ff @(posedge clk)
    begin
        if (srst)
            pulse_q <= 10'h000;
        else if (ce)
            pulse_q <= pulse_d;
    end

    assign bulkInSerialSideClear = pulse_q[0];
    assign bulkInCpuSideClear    = pulse_q[1];
    assign ep0TxBufferClear      = pulse_q[2];
    assign ep0RxBufferClear      = pulse_q[3];
    assign bulkOutFullClear      = pulse_q[4];
    assign bulkOutCpuSideClear   = pulse_q[5];
    assign bulkInNakClear        = pulse_q[6];
    assign ep0TxNakClear         = pulse_q[7];
    assign ep0RxNakClear         = pulse_q[8];
    assign bulkOutNakClear       = pulse_q[9];

endmodule

`default_nettype wire

// file: test/uicr_regs_chk.sv
// checker for the usb interrupt-clear and fifo-clear register bank
// assumes it is bound to uicr_regs and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module uicr_chk
(
    input wire logic        clk,
    input wire logic        srst,
    input wire logic        ce,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic        outEndpointEnable,
    input wire logic        ifaceBulkOutActive,
    input wire logic        bulkOutDataEvent,
    input wire logic        bulkInTokenBusy,
    input wire logic        bulkInNakFlag,
    input wire logic [3:0]  bulkOutIrqStatus,
    input wire logic        bulkInSerialSideClear,
    input wire logic        ep0TxBufferClear,
    input wire logic        ep0TxNakClear,
    input wire logic        bulkInNakClear
);
    logic        wr_q;
    logic [29:0] idx_q;
    wire         rdA = ce && hsel && hready && htrans[1] && !hwrite;
    wire         irqA = haddr[31:2] inside {uicr_pkg::IDX_BULK_OUT_IRQ_CLEAR, uicr_pkg::IDX_SET_INTERFACE_IRQ_CLEAR};
    wire         fifoA = haddr[31:2] inside {uicr_pkg::IDX_EP0_BULK_IN_FIFO_CLEAR, uicr_pkg::IDX_BULK_OUT_FIFO_CLEAR};
    wire         boClr = wr_q && ce && idx_q == uicr_pkg::IDX_BULK_OUT_IRQ_CLEAR && !hwdata[0]
                         && outEndpointEnable && ifaceBulkOutActive;
    wire         fic0 = wr_q && ce && idx_q == uicr_pkg::IDX_EP0_BULK_IN_FIFO_CLEAR;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // remember a write address phase for its data phase
    always_ff @(posedge clk)
    begin
        wr_q <= !srst && ce && hsel && hready && htrans[1] && hwrite;
        idx_q <= haddr[31:2];
    end
    irq_read_a: assert property (
        rdA && irqA |=> hrdata[7:0] == uicr_pkg::IRQ_CLEAR_READ) else $error("irq clear read not all ones");
    fifo_read_a: assert property (
        rdA && fifoA |=> hrdata[7:0] == uicr_pkg::FIFO_CLEAR_READ) else $error("fifo clear read not zero");
    bo_clear_a: assert property (
        boClr && !bulkOutDataEvent |=> !bulkOutIrqStatus[0]) else $error("data source not cleared");
    bo_hold_a: assert property (
        bulkOutIrqStatus[0] && !boClr |=> bulkOutIrqStatus[0]) else $error("data source lost");
    event_wins_a: assert property (
        bulkOutDataEvent |=> bulkOutIrqStatus[0]) else $error("data event not latched");
    tx_pulse_a: assert property (
        fic0 && hwdata[1] |=> ep0TxBufferClear && ep0TxNakClear) else $error("ep0 tx clear missing");
    pulse_drop_a: assert property (
        ep0TxBufferClear |=> !ep0TxBufferClear) else $error("ep0 tx clear stuck");
    ser_block_a: assert property (
        fic0 && bulkInTokenBusy && bulkInNakFlag |=> !bulkInSerialSideClear) else $error("serial clear not blocked");
    ser_nak_a: assert property (
        bulkInSerialSideClear |-> bulkInNakClear) else $error("bulk-in nak flag kept");
    cover property (boClr);
    cover property (fic0 && hwdata[5]);
    cover property (boClr && bulkOutDataEvent);
endmodule
bind uicr_regs uicr_chk chk (.clk, .srst, .ce, .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata, .hrdata,
    .outEndpointEnable, .ifaceBulkOutActive, .bulkOutDataEvent, .bulkInTokenBusy, .bulkInNakFlag,
    .bulkOutIrqStatus, .bulkInSerialSideClear, .ep0TxBufferClear, .ep0TxNakClear, .bulkInNakClear);
`default_nettype wire

// file: test/usb_irq_and_fifo_clear_regs_tb_top.sv
// self-checking bench for the usb interrupt-clear and fifo-clear register bank
// assumes uicr_regs is the only ahb-lite slave and answers with zero wait
`timescale 1ns/1ps
`default_nettype none
module usb_irq_and_fifo_clear_regs_tb_top;
    localparam logic [29:0] IC3 = uicr_pkg::IDX_BULK_OUT_IRQ_CLEAR;
    localparam logic [29:0] IC4 = uicr_pkg::IDX_SET_INTERFACE_IRQ_CLEAR;
    localparam logic [29:0] FC0 = uicr_pkg::IDX_EP0_BULK_IN_FIFO_CLEAR;
    localparam logic [29:0] FC1 = uicr_pkg::IDX_BULK_OUT_FIFO_CLEAR;
    logic        clk = 1'b0;
    logic        srst, hsel, hwrite, inEn, outEn, ifOut, setEv, busy, biNak, hw, setSt, hresp, hreadyout;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [3:0]  boEv, boSt, e4;
    wire  [9:0]  pl;
    int          errors, samples_checked, cyc;
    logic [29:0] ix [5] = '{IC3, IC4, FC0, FC1, 30'h00000100};
    logic [7:0]  rx [5] = '{8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00};
    logic [29:0] fx [7] = '{FC0, FC0, FC0, FC0, FC1, FC1, FC0};
    logic [7:0]  fd [7] = '{8'h20, 8'h10, 8'h02, 8'h01, 8'h02, 8'h01, 8'h00};
    logic [9:0]  fp [7] = '{10'h208, 10'h100, 10'h084, 10'h042, 10'h021, 10'h011, 10'h000};
    uicr_regs dut
    (
        .clk(clk), .srst(srst), .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .inEndpointEnable(inEn), .outEndpointEnable(outEn), .ifaceBulkInActive(1'b1), .ifaceBulkOutActive(ifOut),
        .bulkOutFullEvent(boEv[3]), .bulkOutNullEvent(boEv[2]), .bulkOutNakEvent(boEv[1]),
        .bulkOutDataEvent(boEv[0]), .setInterfaceEvent(setEv), .bulkInTokenBusy(busy), .bulkInNakFlag(biNak),
        .ep0RxNakSetByHw(hw), .bulkOutNakSetByHw(hw), .bulkOutIrqStatus(boSt), .setInterfaceIrqStatus(setSt),
        .bulkInSerialSideClear(pl[9]), .bulkInCpuSideClear(pl[8]), .ep0TxBufferClear(pl[7]),
        .ep0RxBufferClear(pl[6]), .bulkOutFullClear(pl[5]), .bulkOutCpuSideClear(pl[4]),
        .bulkInNakClear(pl[3]), .ep0TxNakClear(pl[2]), .ep0RxNakClear(pl[1]), .bulkOutNakClear(pl[0])
    );
    // free-running clock
    initial
    begin
        forever #5 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic results();
        if (errors == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // one ahb-lite single transfer; read data taken at the closing edge
    task automatic xfer(input logic w, input logic [29:0] i, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {i, 2'b00};
        htrans <= uicr_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    // write, then settle into the cycle where clear pulses stand
    task automatic wr(input logic [29:0] i, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, i, d, q);
        #1;
    endtask
    task automatic ev(input logic [3:0] b, input logic s);
        @(posedge clk);
        boEv <= b;
        setEv <= s;
        @(posedge clk);
        boEv <= 4'h0;
        setEv <= 1'b0;
    endtask
    // cut a hang short
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 2000)
        begin
            errors++;
            results();
        end
    end
    // main sequence
    initial
    begin
        {hsel, hwrite, htrans, haddr, hwdata, boEv, setEv, busy, biNak, hw} = '0;
        {inEn, outEn, ifOut, srst} = 4'hF;
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        for (int k = 0; k < 5; k++)
        begin
            xfer(1'b0, ix[k], 32'h0, r);
            chk("read", r & 32'hFF, rx[k]);
        end
        ev(4'hF, 1'b1);
        wr(IC3, 32'hFF);
        e4 = 4'hF;
        chk("bo status", boSt, e4);
        for (int b = 0; b < 4; b++)
        begin
            wr(IC3, ~(32'h1 << b));
            e4[b] = 1'b0;
            chk("bo status", boSt, e4);
        end
        xfer(1'b0, IC3, 32'h0, r);
        chk("read", r & 32'hFF, 32'hFF);
        wr(IC4, 32'h20);
        chk("set status", setSt, 1'b1);
        wr(IC4, 32'hDF);
        chk("set status", setSt, 1'b0);
        ev(4'hF, 1'b0);
        @(posedge clk) outEn <= 1'b0;
        wr(IC3, 32'h0);
        @(posedge clk) {outEn, ifOut} <= 2'h2;
        wr(IC3, 32'h0);
        @(posedge clk) ifOut <= 1'b1;
        wr(30'h00000100, 32'h0);
        chk("bo status", boSt, 4'hF);
        fork
            wr(IC3, 32'hFE);
            begin
                repeat (2) @(posedge clk);
                boEv <= 4'h1;
                @(posedge clk);
                boEv <= 4'h0;
            end
        join
        chk("bo status", boSt, 4'hF);
        for (int h = 0; h < 2; h++)
        begin
            @(posedge clk) hw <= h[0];
            for (int k = 0; k < 7; k++)
            begin
                wr(fx[k], {24'h0, fd[k]});
                chk("pulses", pl, h[0] ? fp[k] : fp[k] & 10'h3FC);
                @(posedge clk);
                #1;
                chk("pulses", pl, 10'h0);
            end
        end
        @(posedge clk) {busy, biNak, inEn} <= 3'h7;
        wr(FC0, 32'h10);
        wr(FC0, 32'h20);
        chk("pulses", pl, 10'h0);
        @(posedge clk) {busy, biNak, inEn} <= 3'h0;
        wr(FC0, 32'h30);
        chk("pulses", pl, 10'h0);
        results();
    end
endmodule
`default_nettype wire
